// *** dss_pkg.sv ***
// Constants and types shared by the standard-switch control block
package dss_pkg;
   // ==========================================================
   // Management register indices; byte address is four times
   localparam int unsigned IDX_CTRL     = 0;
   localparam int unsigned IDX_STATUS   = 1;
   localparam int unsigned IDX_ADV      = 4;
   localparam int unsigned IDX_LP       = 5;
   localparam int unsigned IDX_LAST_STD = 16;
   localparam int unsigned IDX_SWITCH   = 17;
   localparam int unsigned IDX_COUNT    = 18;
   localparam int unsigned BYTES_PER_REG = 4;

   // ==========================================================
   // Field positions
   localparam int unsigned CTRL_SPEED_LSB = 13;
   localparam int unsigned CTRL_AN_EN     = 12;
   localparam int unsigned CTRL_RESTART   = 9;
   localparam int unsigned CTRL_DUPLEX    = 8;
   localparam int unsigned CTRL_SPEED_MSB = 6;
   localparam int unsigned STAT_EXT       = 8;
   localparam int unsigned STAT_AN_DONE   = 5;
   localparam int unsigned STAT_AN_ABLE   = 3;
   localparam int unsigned STAT_LINK      = 2;
   localparam int unsigned LP_SPEED_MSB   = 11;
   localparam int unsigned LP_SPEED_LSB   = 10;
   localparam int unsigned SW_STD         = 0;

   // ==========================================================
   // Reset values and fixed words
   localparam logic [15:0] ADV_RESET  = 16'h0020;
   localparam logic [15:0] SGMII_ADV  = 16'h0001;
   localparam logic        AN_EN_RESET = 1'b1;

   // ==========================================================
   // Link timer, in ns as printed, and cycles at 40 MHz
   localparam int unsigned CLK_PERIOD_NS   = 25;
   localparam int unsigned LT_BASEX_NS     = 10_000_000;
   localparam int unsigned LT_SGMII_NS     = 1_600_000;
   localparam int unsigned LT_BASEX_CYC    = LT_BASEX_NS / CLK_PERIOD_NS;
   localparam int unsigned LT_SGMII_CYC    = LT_SGMII_NS / CLK_PERIOD_NS;

   typedef enum logic {
      DSS_STD_BASEX = 1'b0,
      DSS_STD_SGMII = 1'b1
   } dss_std_t;

   typedef enum logic [1:0] {
      AN_IDLE = 2'b00,
      AN_RUN  = 2'b01,
      AN_DONE = 2'b11
   } dss_an_state_t;
endpackage

// *** dss_an_if.sv ***
// Signals between the register front end and the negotiation engine
`timescale 1ns/1ps
interface dss_an_if;
   import dss_pkg::*;
   logic     an_enable;
   logic     restart;
   dss_std_t std_sel;
   logic     lp_valid;
   logic     busy;
   logic     complete;
   dss_std_t an_std;

   modport ctrl (output an_enable, restart, std_sel, lp_valid,
                 input busy, complete, an_std);
   modport fsm  (input an_enable, restart, std_sel, lp_valid,
                 output busy, complete, an_std);
endinterface

// *** dss_an_fsm.sv ***
// Auto-negotiation sequencer with per-standard link timer
`timescale 1ns/1ps
module dss_an_fsm
   import dss_pkg::*;
#(
   parameter int unsigned LT_BASEX = LT_BASEX_CYC,
   parameter int unsigned LT_SGMII = LT_SGMII_CYC
) (
   input  wire logic clk_sys,  // System clock
   input  wire logic resetn,   // Synchronous reset, active low
   dss_an_if.fsm     an        // Control and status
);
   localparam int unsigned CNT_W =
      $clog2((LT_BASEX > LT_SGMII ? LT_BASEX : LT_SGMII) + 1);

   generate
      if (LT_BASEX < 2 || LT_SGMII < 2) begin : g_chk
         $error("link timer counts must be at least two cycles");
      end
   endgenerate

   dss_an_state_t    state_reg;
   dss_an_state_t    state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic             lp_seen_reg;
   dss_std_t         std_reg;
   wire  [CNT_W-1:0] limit;
   wire              expired;
   wire              start;

   // ==========================================================
   // Timer length follows the standard latched at start
   assign limit   = (std_reg == DSS_STD_SGMII) ?
                    CNT_W'(LT_SGMII - 1) : CNT_W'(LT_BASEX - 1);
   assign expired = (cnt_reg == limit);
   assign start   = an.an_enable &&
                    (an.restart || state_reg == AN_IDLE);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         AN_IDLE: if (start) state_next = AN_RUN;
         AN_RUN: begin
            if (expired && (lp_seen_reg || an.lp_valid)) begin
               state_next = AN_DONE;
            end
         end
         AN_DONE: if (an.restart) state_next = AN_RUN;
         default: state_next = AN_IDLE;
      endcase
      if (!an.an_enable) begin
         state_next = AN_IDLE;
      end else if (an.restart) begin
         state_next = AN_RUN;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_reg   <= AN_IDLE;
         cnt_reg     <= '0;
         lp_seen_reg <= 1'b0;
         std_reg     <= DSS_STD_BASEX;
      end else begin
         state_reg <= state_next;
         if (start) begin
            std_reg     <= an.std_sel;
            cnt_reg     <= '0;
            lp_seen_reg <= 1'b0;
         end else if (state_reg == AN_RUN) begin
            cnt_reg     <= expired ? '0 : cnt_reg + 1'b1;
            lp_seen_reg <= lp_seen_reg | an.lp_valid;
         end
      end
   end

   assign an.busy     = (state_reg == AN_RUN);
   assign an.complete = (state_reg == AN_DONE);
   assign an.an_std   = std_reg;

   // ==========================================================
   // Checks
   sequence run_started;
      $rose(state_reg == AN_RUN);
   endsequence

   std_latch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      run_started |-> std_reg == $past(an.std_sel))
      else $error("negotiation did not take the selected standard");

   std_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      an.busy && !$past(start) && !start |-> $stable(std_reg))
      else $error("standard changed during a negotiation");

   timer_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(state_reg == AN_DONE) |-> $past(cnt_reg) == $past(limit)
      && ($past(std_reg) == DSS_STD_SGMII ?
          $past(limit) == CNT_W'(LT_SGMII - 1) :
          $past(limit) == CNT_W'(LT_BASEX - 1)))
      else $error("negotiation ended off the link timer");
endmodule

// *** dss_switch_ctrl.sv ***
// APB register front end for 1000BASE-X / SGMII standard switching
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module dss_switch_ctrl
   import dss_pkg::*;
#(
   parameter int unsigned ADDR_W   = 8,
   parameter int unsigned LT_BASEX = LT_BASEX_CYC,
   parameter int unsigned LT_SGMII = LT_SGMII_CYC
) (
   input  wire logic              clk_sys,        // System clock
   input  wire logic              resetn,         // Sync reset, low
   input  wire logic              std_strap,      // Reset standard
   input  wire logic              psel,           // APB select
   input  wire logic              penable,        // APB enable
   input  wire logic              pwrite,         // APB direction
   input  wire logic [ADDR_W-1:0] paddr,          // APB byte address
   input  wire logic [31:0]       pwdata,         // APB write data
   output logic      [31:0]       prdata,         // APB read data
   output logic                   pready,         // APB ready
   output logic                   pslverr,        // APB error
   input  wire logic              lp_valid,       // Partner word strobe
   input  wire logic [15:0]       lp_ability,     // Partner word
   output logic                   std_sgmii,      // Standard in force
   output logic                   an_std_sgmii,   // Standard of negotiation
   output logic                   an_complete,    // Negotiation done
   output logic                   mac_full_duplex // Duplex to MAC
);
   generate
      if (ADDR_W < 7 || ADDR_W > 16) begin : g_chk
         $error("ADDR_W must hold the switching register address");
      end
   endgenerate

   // ==========================================================
   // Address decoding helpers
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input int unsigned idx);
      hit = (a == ADDR_W'(idx * BYTES_PER_REG));
   endfunction

   dss_an_if an ();

   logic        sw_reg;
   logic        an_en_reg;
   logic        restart_reg;
   logic [15:0] adv_reg;
   logic [15:0] lp_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        done_reg;
   logic        an_std_reg;
   logic        duplex_reg;

   wire         setup     = psel && !penable;
   wire         access_ok = psel && penable && pready_reg;
   wire         wr        = access_ok && pwrite;
   wire         aligned   = (paddr[1:0] == 2'b00);
   wire         mapped    = aligned &&
                            (paddr < ADDR_W'(IDX_COUNT * BYTES_PER_REG));
   wire         wr_ctrl   = wr && hit(paddr, IDX_CTRL);
   wire         wr_adv    = wr && hit(paddr, IDX_ADV);
   wire         wr_sw     = wr && hit(paddr, IDX_SWITCH);
   wire         en_next   = wr_ctrl ? pwdata[CTRL_AN_EN] : an_en_reg;
   wire         en_rise   = en_next && !an_en_reg;
   wire         restart_next = wr_ctrl &&
                               (pwdata[CTRL_RESTART] || en_rise);
   wire         sw_next   = wr_sw ? pwdata[SW_STD] : sw_reg;

   // ==========================================================
   // Standard-dependent register view
   wire         view_sgmii = (sw_reg == DSS_STD_SGMII);
   wire         spd_msb    = view_sgmii ? lp_reg[LP_SPEED_MSB] : 1'b1;
   wire         spd_lsb    = view_sgmii ? lp_reg[LP_SPEED_LSB] : 1'b0;
   wire  [15:0] ctrl_word;
   wire  [15:0] stat_word;
   wire  [15:0] adv_word;
   wire  [15:0] rd_word;

   assign ctrl_word = (16'(spd_lsb) << CTRL_SPEED_LSB)
                    | (16'(an_en_reg) << CTRL_AN_EN)
                    | (16'(1'b1) << CTRL_DUPLEX)
                    | (16'(spd_msb) << CTRL_SPEED_MSB);
   assign stat_word = (16'(1'b1) << STAT_EXT)
                    | (16'(done_reg) << STAT_AN_DONE)
                    | (16'(1'b1) << STAT_AN_ABLE)
                    | (16'(done_reg) << STAT_LINK);
   assign adv_word  = view_sgmii ? SGMII_ADV : adv_reg;
   assign rd_word   = hit(paddr, IDX_CTRL)   ? ctrl_word :
                      hit(paddr, IDX_STATUS) ? stat_word :
                      hit(paddr, IDX_ADV)    ? adv_word  :
                      hit(paddr, IDX_LP)     ? lp_reg    :
                      hit(paddr, IDX_SWITCH) ? 16'(sw_reg) :
                      16'h0000;

   // ==========================================================
   // APB slave: one wait-free access phase
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !mapped;
         if (setup) begin
            prdata_reg <= (mapped && !pwrite) ? {16'h0000, rd_word}
                                              : 32'h00000000;
         end
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sw_reg      <= std_strap;
         an_en_reg   <= AN_EN_RESET;
         restart_reg <= 1'b0;
         adv_reg     <= ADV_RESET;
         lp_reg      <= 16'h0000;
      end else begin
         sw_reg      <= sw_next;
         an_en_reg   <= en_next;
         restart_reg <= restart_next;
         if (wr_adv) begin
            adv_reg <= pwdata[15:0];
         end
         if (lp_valid) begin
            lp_reg <= lp_ability;
         end
      end
   end

   // ==========================================================
   // Registered copies for the outputs
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         done_reg   <= 1'b0;
         an_std_reg <= 1'b0;
         duplex_reg <= 1'b0;
      end else begin
         done_reg   <= an.complete;
         an_std_reg <= an.an_std;
         duplex_reg <= 1'b1;
      end
   end

   assign an.an_enable = an_en_reg;
   assign an.restart   = restart_reg;
   assign an.std_sel   = dss_std_t'(sw_reg);
   assign an.lp_valid  = lp_valid;

   dss_an_fsm #(
      .LT_BASEX (LT_BASEX),
      .LT_SGMII (LT_SGMII)
   ) u_an (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .an      (an)
   );

   assign prdata          = prdata_reg;
   assign pready          = pready_reg;
   assign pslverr         = pslverr_reg;
   assign std_sgmii       = sw_reg;
   assign an_std_sgmii    = an_std_reg;
   assign an_complete     = done_reg;
   assign mac_full_duplex = duplex_reg;

   // ==========================================================
   // Checks
   logic [31:0] run_len_reg;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         run_len_reg <= 32'h00000000;
      end else if (an.busy && !an.restart) begin
         run_len_reg <= run_len_reg + 32'h00000001;
      end else begin
         run_len_reg <= 32'h00000000;
      end
   end

   sequence sw_write;
      wr_sw;
   endsequence

   sequence apb_setup;
      psel && !penable;
   endsequence

   sequence apb_read;
      psel && !penable && !pwrite;
   endsequence

   sequence an_finished;
      $rose(an.complete);
   endsequence

   strap_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(resetn) && !$past(std_strap) |-> !std_sgmii)
      else $error("strap low did not give 1000BASE-X");

   strap_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(resetn) && $past(std_strap) |-> std_sgmii)
      else $error("strap high did not give SGMII");

   switch_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      sw_write |=> std_sgmii == $past(pwdata[SW_STD]))
      else $error("switching write not applied");

   switch_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      !wr_sw |=> $stable(std_sgmii))
      else $error("standard changed without a write");

   adv_view_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      apb_read ##0 hit(paddr, IDX_ADV) |=>
      prdata[15:0] == ($past(std_sgmii) ? SGMII_ADV : $past(adv_reg)))
      else $error("advertisement view wrong for standard");

   no_restart_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_sw && an.complete |=>
      !restart_reg && an.complete ##1 an.complete)
      else $error("switching restarted negotiation");

   restart_bit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_ctrl && pwdata[CTRL_RESTART] && pwdata[CTRL_AN_EN]
      |=> restart_reg ##1 an.busy)
      else $error("restart bit did not start negotiation");

   apb_ready_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      apb_setup |=> pready ##1 !pready)
      else $error("APB answer not in the first access cycle");

   duplex_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $past(resetn) |-> mac_full_duplex)
      else $error("MAC duplex not forced full");

   timer_mult_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      an_finished |-> run_len_reg != 32'h00000000 &&
      run_len_reg % (an.an_std == DSS_STD_SGMII ? LT_SGMII : LT_BASEX) == 0)
      else $error("negotiation length not a link timer multiple");

   err_resp_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      apb_setup ##0 !mapped |=>
      pready && pslverr && prdata == 32'h00000000)
      else $error("unmapped access not refused");

   wr_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      apb_setup ##0 pwrite |=>
      prdata == 32'h00000000)
      else $error("write returned read data");

   lp_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      lp_valid |=> lp_reg == $past(lp_ability))
      else $error("partner word not captured");

   lp_view_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      apb_read ##0 hit(paddr, IDX_LP) |=>
      prdata == {16'h0000, $past(lp_reg)})
      else $error("partner word read back wrong");

   stat_view_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      apb_read ##0 hit(paddr, IDX_STATUS) |=>
      prdata[STAT_AN_DONE] == $past(done_reg))
      else $error("status done bit read back wrong");

   speed_view_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      apb_read ##0 hit(paddr, IDX_CTRL) |=>
      prdata[CTRL_SPEED_MSB] == ($past(std_sgmii) ?
                                 $past(lp_reg[LP_SPEED_MSB]) : 1'b1))
      else $error("speed field view wrong for standard");

   enable_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_ctrl && !pwdata[CTRL_AN_EN] |=>
      ##1 !an.busy && !an.complete)
      else $error("negotiation kept running while disabled");

   restart_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      restart_reg |=> !restart_reg)
      else $error("restart pulse longer than one cycle");

   adv_store_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_adv |=> adv_reg == $past(pwdata[15:0]))
      else $error("advertisement write not stored");
endmodule

// *** dss_mac_model.sv ***
// Behavioural MAC-side partner: ability words and duplex watch
`timescale 1ns/1ps
module dss_mac_model (
   input  wire logic        clk_sys,         // Clock shared with the block
   input  wire logic        resetn,          // Sync reset, active low
   input  wire logic        mac_full_duplex, // Duplex from block
   output logic             lp_valid,        // Ability word strobe
   output logic [15:0]      lp_ability,      // Ability word
   output logic             duplex_fault     // Half duplex seen
);
   logic resetn_d;

   // ==========================================================
   // Idle state
   initial begin
      lp_valid     = 1'b0;
      lp_ability   = 16'h5A5A;
      duplex_fault = 1'b0;
      resetn_d     = 1'b0;
   end

   // ==========================================================
   // MAC runs full duplex on the one shared clock
   always @(posedge clk_sys) begin
      if (resetn && resetn_d && mac_full_duplex !== 1'b1) begin
         duplex_fault <= 1'b1;
      end
      resetn_d <= resetn;
   end

   // ==========================================================
   // One-cycle strobe; word line scrambled once released
   task automatic send_word(input logic [15:0] w);
      lp_valid   <= 1'b1;
      lp_ability <= w;
      @(posedge clk_sys);
      lp_valid   <= 1'b0;
      lp_ability <= ~w;
      @(posedge clk_sys);
   endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the standard-switch control block
`timescale 1ns/1ps
module tb
   import dss_pkg::*;
;
   localparam int unsigned LTB = 40;
   localparam int unsigned LTS = 16;
   localparam logic [31:0] CTRL_GO = (32'h1 << CTRL_AN_EN)
                                   | (32'h1 << CTRL_RESTART);
   logic        clk_sys;
   logic        resetn;
   logic        std_strap;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        lp_valid;
   logic [15:0] lp_ability;
   logic        std_sgmii;
   logic        an_std_sgmii;
   logic        an_complete;
   logic        mac_full_duplex;
   logic        duplex_fault;
   logic [31:0] rd;
   logic        er;
   logic        s;
   logic [15:0] adv;
   logic [15:0] w;
   int          num_errors;
   int          compares;

   initial clk_sys = 1'b0;
   always #12.5 clk_sys = ~clk_sys;

   dss_switch_ctrl #(.ADDR_W(8), .LT_BASEX(LTB), .LT_SGMII(LTS))
      dss_switch_ctrl_i (.clk_sys(clk_sys), .resetn(resetn),
      .std_strap(std_strap), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lp_valid(lp_valid),
      .lp_ability(lp_ability), .std_sgmii(std_sgmii),
      .an_std_sgmii(an_std_sgmii), .an_complete(an_complete),
      .mac_full_duplex(mac_full_duplex));

   dss_mac_model dss_mac_model_i (.clk_sys(clk_sys), .resetn(resetn),
      .mac_full_duplex(mac_full_duplex), .lp_valid(lp_valid),
      .lp_ability(lp_ability), .duplex_fault(duplex_fault));

   // ==========================================================
   // Expectations and comparisons
   function automatic logic [7:0] ba(input int unsigned idx);
      return 8'(idx * BYTES_PER_REG);
   endfunction

   function automatic logic [31:0] exp_ctrl(input logic sg,
                                            input logic [15:0] lp);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[CTRL_AN_EN]     = AN_EN_RESET;
      v[CTRL_DUPLEX]    = 1'b1;
      v[CTRL_SPEED_MSB] = sg ? lp[LP_SPEED_MSB] : 1'b1;
      v[CTRL_SPEED_LSB] = sg ? lp[LP_SPEED_LSB] : 1'b0;
      return v;
   endfunction

   function automatic logic [31:0] exp_stat(input logic done);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[STAT_EXT]     = 1'b1;
      v[STAT_AN_ABLE] = 1'b1;
      v[STAT_AN_DONE] = done;
      v[STAT_LINK]    = done;
      return v;
   endfunction

   task automatic chk_word(input string what, input logic [31:0] e,
                           input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_bit(input string what, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask

   // ==========================================================
   // APB master: setup, access until pready, release
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk_bit("pready", 1'b1, pready);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wait_done(input logic e, input int unsigned lim);
      int n;
      n = 0;
      while (an_complete !== e && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      chk_bit("an_complete", e, an_complete);
   endtask

   task automatic do_reset(input logic st);
      resetn    <= 1'b0;
      std_strap <= st;
      repeat (2) @(posedge clk_sys);
      resetn    <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk_bit("std_sgmii", st, std_sgmii);
      chk_bit("full_duplex", 1'b1, mac_full_duplex);
      apb(1'b0, ba(IDX_SWITCH), 32'h0);
      chk_word("switch", {31'h0, st}, rd);
   endtask

   task automatic tally_and_finish;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #750_000;
      num_errors++;
      tally_and_finish();
   end

   // ==========================================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      std_strap = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      num_errors = 0;
      compares = 0;
      adv = ADV_RESET;
      void'($urandom(32'hE5F2));
      do_reset(1'b0);
      apb(1'b0, ba(IDX_CTRL), 32'h0);
      chk_word("ctrl", exp_ctrl(1'b0, 16'h0), rd);
      apb(1'b0, ba(IDX_ADV), 32'h0);
      chk_word("adv", {16'h0, ADV_RESET}, rd);
      // Switch while the first negotiation is still running
      apb(1'b1, ba(IDX_SWITCH), 32'h1);
      chk_bit("std_sgmii", 1'b1, std_sgmii);
      chk_bit("an_std", 1'b0, an_std_sgmii);
      apb(1'b0, ba(IDX_ADV), 32'h0);
      chk_word("adv", {16'h0, SGMII_ADV}, rd);
      w = 16'($urandom());
      dss_mac_model_i.send_word(w);
      wait_done(1'b1, 2 * LTB + 8);
      chk_bit("an_std", 1'b0, an_std_sgmii);
      apb(1'b0, ba(IDX_CTRL), 32'h0);
      chk_word("ctrl", exp_ctrl(1'b1, w), rd);
      apb(1'b0, ba(IDX_STATUS), 32'h0);
      chk_word("status", exp_stat(1'b1), rd);
      apb(1'b1, ba(IDX_SWITCH), 32'h0);
      repeat (2 * LTB) @(posedge clk_sys);
      chk_bit("an_complete", 1'b1, an_complete);
      // Recommended follow-up after each switch, both standards
      for (int i = 0; i < 2; i++) begin
         s = (i == 0);
         apb(1'b1, ba(IDX_SWITCH), {31'h0, s});
         if (!s) begin
            adv = 16'($urandom());
            apb(1'b1, ba(IDX_ADV), {16'h0, adv});
         end
         apb(1'b1, ba(IDX_CTRL), CTRL_GO);
         wait_done(1'b0, 6);
         repeat (2) @(posedge clk_sys);
         chk_bit("an_std", s, an_std_sgmii);
         w = 16'($urandom());
         dss_mac_model_i.send_word(w);
         wait_done(1'b1, (s ? LTS : LTB) + 8);
         apb(1'b0, ba(IDX_ADV), 32'h0);
         chk_word("adv", {16'h0, s ? SGMII_ADV : adv}, rd);
         apb(1'b0, ba(IDX_CTRL), 32'h0);
         chk_word("ctrl", exp_ctrl(s, w), rd);
      end
      // Random partner words and random switching
      for (int i = 0; i < 6; i++) begin
         w = 16'($urandom());
         dss_mac_model_i.send_word(w);
         apb(1'b1, ba(IDX_LP), $urandom());
         apb(1'b0, ba(IDX_LP), 32'h0);
         chk_word("lp", {16'h0, w}, rd);
         apb(1'b1, ba(IDX_SWITCH), {31'h0, w[0]});
         chk_bit("std_sgmii", w[0], std_sgmii);
         apb(1'b0, ba(IDX_CTRL), 32'h0);
         chk_bit("pslverr", 1'b0, er);
         chk_word("ctrl", exp_ctrl(w[0], w), rd);
      end
      apb(1'b1, ba(IDX_SWITCH), 32'h0000_FFFE);
      chk_bit("std_sgmii", 1'b0, std_sgmii);
      apb(1'b0, ba(2), 32'h0);
      chk_word("reserved", 32'h0, rd);
      apb(1'b1, 8'h48, 32'h1);
      chk_bit("pslverr", 1'b1, er);
      apb(1'b0, 8'h02, 32'h0);
      chk_bit("pslverr", 1'b1, er);
      chk_word("unaligned", 32'h0, rd);
      // Enable off stops negotiation; enable back on restarts it
      apb(1'b1, ba(IDX_CTRL), 32'h0);
      wait_done(1'b0, 6);
      apb(1'b0, ba(IDX_CTRL), 32'h0);
      chk_word("ctrl_off", exp_ctrl(1'b0, w) & ~CTRL_GO, rd);
      apb(1'b1, ba(IDX_CTRL), CTRL_GO & ~(32'h1 << CTRL_RESTART));
      dss_mac_model_i.send_word(w);
      wait_done(1'b1, LTB + 8);
      // Standard switched by register, then reset with strap low and high
      apb(1'b1, ba(IDX_SWITCH), 32'h1);
      do_reset(1'b0);
      do_reset(1'b1);
      chk_bit("an_std", 1'b1, an_std_sgmii);
      apb(1'b0, ba(IDX_ADV), 32'h0);
      chk_word("adv", {16'h0, SGMII_ADV}, rd);
      chk_bit("duplex_fault", 1'b0, duplex_fault);
      tally_and_finish();
   end
endmodule
